// [common/fspg_cfg.svh]
// Constants for the flash sector protect and write guard host controller
`ifndef FSPG_CFG_SVH
`define FSPG_CFG_SVH
// Functional notes
// RL1: HV protect: A9, OE high-voltage, A6=0 A1=1 A0=0
// RL2: Device unprotect clears all sectors together
// RL3: Protect every sector before first unprotect cycle
// RL4: Re-protect wanted sectors one by one afterwards
// RL5: In-system unprotect: reset high-voltage, A6=1 A1=1 A0=0
// RL6: HV unprotect: A9, OE high-voltage, A6=1 A1=1 A0=0
// RL7: Reset high-voltage held gives temporary unprotect
// RL8: Removing reset high-voltage restores earlier protection
// RL9: Power-up clears device state, array read mode
// RL10: Only complete command sequences alter memory
// RL11: Below lockout threshold all writes ignored
// RL12: Strobe pulses under 5 ns start nothing
// RL13: Write only with CE, WE low, OE high
// RL14: Strobes low at power-up give no command
// RL15: Word mode A19:A0; byte mode adds A-1 on DQ15
// RL16: Long reset low aborts, floats, returns read mode
// RL17: Width pin high sixteen lines, low eight lines
// RL18: High-voltage levels modelled as digital qualifiers

// ------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define FSPG_OFF_CTRL    8'h00
`define FSPG_OFF_ADDR    8'h04
`define FSPG_OFF_WDATA   8'h08
`define FSPG_OFF_STATUS  8'h0c
// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define FSPG_CTRL_OP_LSB   0
`define FSPG_CTRL_BYTE     4
`define FSPG_CTRL_TEMP     5
`define FSPG_CTRL_CONFIRM  6
`define FSPG_CTRL_GO       8
// ------------------------------------------------------------
// Address, status fields and reset values
// ------------------------------------------------------------
`define FSPG_ADDR_LSB_BIT  20
`define FSPG_ST_BUSY       0
`define FSPG_ST_DONE       1
`define FSPG_ST_REFUSED    2
`define FSPG_ST_REPROT     3
`define FSPG_ST_RDYBUSY    4
`define FSPG_ST_RDATA_LSB  16
`define FSPG_RST_ADDR      21'h000000
`define FSPG_RST_WDATA     16'h0000
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define FSPG_CLK_PS        5000
`define FSPG_GLITCH_NS     5
`define FSPG_SETUP_NS      40
`define FSPG_STROBE_NS     100
`define FSPG_RECOV_NS      40
`define FSPG_RSTLOW_NS     500
`define FSPG_NS2CYC(ns)    (((ns) * 1000 + `FSPG_CLK_PS - 1) / `FSPG_CLK_PS)
`define FSPG_SETUP_CYC     `FSPG_NS2CYC(`FSPG_SETUP_NS)
`define FSPG_STROBE_CYC    `FSPG_NS2CYC(`FSPG_STROBE_NS)
`define FSPG_RECOV_CYC     `FSPG_NS2CYC(`FSPG_RECOV_NS)
`define FSPG_RSTLOW_CYC    `FSPG_NS2CYC(`FSPG_RSTLOW_NS)
`define FSPG_GLITCH_CYC    `FSPG_NS2CYC(`FSPG_GLITCH_NS)
`endif

// [common/fspg_pkg.sv]
// Types for the flash sector protect and write guard host controller
package fspg_pkg;
  typedef enum logic [2:0] {
    OP_READ       = 3'b000,
    OP_WRITE      = 3'b001,
    OP_PROT_SYS   = 3'b010,
    OP_UNPROT_SYS = 3'b011,
    OP_PROT_HV    = 3'b100,
    OP_UNPROT_HV  = 3'b101,
    OP_RESET      = 3'b110,
    OP_NONE       = 3'b111
  } fspg_op_e;
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_SETUP  = 3'b001,
    S_STROBE = 3'b010,
    S_RECOV  = 3'b011,
    S_RSTLOW = 3'b100
  } fspg_state_e;
endpackage

// [hw/fspg_sync.sv]
// Three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ps
module fspg_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Pin side and synchronised side
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  wire  [W-1:0] agree = ~(stage2 ^ stage3);

  // A change is taken only once the second and third stages agree
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1  <= '0;
      stage2  <= '0;
      stage3  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= pinIn;
      stage2  <= stage1;
      stage3  <= stage2;
      syncOut <= (stage3 & agree) | (syncOut & ~agree);
    end
  end
endmodule // fspg_sync

// [hw/fspg_host.sv]
// Host controller driving flash pins for protect, unprotect and guarded bus cycles
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fspg_cfg.svh"
module fspg_host import fspg_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Flash pins
  output logic [19:0]            flashAddr,
  output logic [15:0]            dqOut,
  output logic [15:0]            dqDriveN,
  input  wire logic [15:0]       dqIn,
  output logic                   chipEnableN,
  output logic                   outputEnableN,
  output logic                   writeEnableN,
  output logic                   resetN,
  output logic                   byteN,
  input  wire logic              rdyBusyN,
  // High-voltage level qualifiers
  output logic                   hvResetQual,
  output logic                   hvAddressNineQual,
  output logic                   hvOutputEnableQual
);
  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    regHit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  logic [ADDR_W-1:0] awAddrQ;
  logic [31:0]       wDataQ;
  logic [3:0]        wStrbQ;
  logic              awHeld;
  logic              wHeld;
  fspg_op_e          opReg;
  logic              byteMode;
  logic              tempUnprot;
  logic              protConfirm;
  logic [20:0]       addrReg;
  logic [15:0]       wdataReg;
  logic [15:0]       rdData;
  logic              doneFlag;
  logic              refusedFlag;
  logic              reprotPend;
  fspg_state_e       state;
  logic [7:0]        cnt;
  logic [15:0]       dqSync;
  logic [0:0]        rdySync;

  wire wrFire   = awHeld & wHeld & ~s_axi_bvalid;
  wire hitCtrl  = regHit(awAddrQ, `FSPG_OFF_CTRL);
  wire hitAddr  = regHit(awAddrQ, `FSPG_OFF_ADDR);
  wire hitWdata = regHit(awAddrQ, `FSPG_OFF_WDATA);
  wire hitStat  = regHit(awAddrQ, `FSPG_OFF_STATUS);
  wire wrCtrl0  = wrFire & hitCtrl & wStrbQ[0];
  wire wrStat   = wrFire & hitStat & wStrbQ[0];
  wire wrMapped = hitCtrl | hitAddr | hitWdata | hitStat;
  wire rdCtrl   = regHit(s_axi_araddr, `FSPG_OFF_CTRL);
  wire rdAddr   = regHit(s_axi_araddr, `FSPG_OFF_ADDR);
  wire rdWdata  = regHit(s_axi_araddr, `FSPG_OFF_WDATA);
  wire rdStat   = regHit(s_axi_araddr, `FSPG_OFF_STATUS);
  wire rdMapped = rdCtrl | rdAddr | rdWdata | rdStat;

  wire      [31:0] ctrlWord = {23'h000000, 1'b0, 1'b0, protConfirm, tempUnprot, byteMode,
                               1'b0, opReg};
  wire      [31:0] statWord = {rdData, 11'h000, rdySync[0], reprotPend, refusedFlag,
                               doneFlag, (state != S_IDLE)};
  wire      [31:0] next_rdata = rdCtrl  ? ctrlWord :
                                rdAddr  ? {11'h000, addrReg} :
                                rdWdata ? {16'h0000, wdataReg} :
                                rdStat  ? statWord : 32'h00000000;

  // Write address and data are taken independently, answered when both are held
  always_ff @(posedge clk) begin
    if (srst) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= ~awHeld & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~wHeld & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld  <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld  <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        awHeld        <= 1'b0;
        wHeld         <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= rdMapped ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= ~s_axi_rvalid;
    end
  end

  // ------------------------------------------------------------
  // Order decode
  // ------------------------------------------------------------
  wire [2:0] newOpBits = wDataQ[`FSPG_CTRL_OP_LSB +: 3];
  wire       newConfirm = wDataQ[`FSPG_CTRL_CONFIRM];
  wire       goReq  = wrFire & hitCtrl & wStrbQ[1] & wDataQ[`FSPG_CTRL_GO];
  wire       goIdle = goReq & (state == S_IDLE);
  wire       isUnprotOp = (newOpBits == OP_UNPROT_SYS) | (newOpBits == OP_UNPROT_HV);
  // Unprotect is refused until software confirms all sectors were protected first
  wire       refuse = goIdle & ((isUnprotOp & ~newConfirm) | (newOpBits == OP_NONE)); // [RL3]
  wire       start  = goIdle & ~refuse;
  wire       cntZero = (cnt == 8'h00);
  // A new order steers the pins from its first setup cycle, not the old one
  wire [2:0] opNow     = (wrCtrl0 & (state == S_IDLE)) ? newOpBits : opReg;
  wire       opIsWrite = (opNow != OP_READ);
  wire       opInSys = (opNow == OP_PROT_SYS) | (opNow == OP_UNPROT_SYS);
  wire       opHv = (opNow == OP_PROT_HV) | (opNow == OP_UNPROT_HV);
  wire       opUnprot = (opNow == OP_UNPROT_SYS) | (opNow == OP_UNPROT_HV);
  wire       opProt = opInSys | opHv;
  wire       cycleEnd = (state == S_RECOV) & cntZero;

  always_ff @(posedge clk) begin
    if (srst) begin
      opReg       <= OP_READ;
      byteMode    <= 1'b0;
      tempUnprot  <= 1'b0;
      protConfirm <= 1'b0;
      addrReg     <= `FSPG_RST_ADDR;
      wdataReg    <= `FSPG_RST_WDATA;
    end else begin
      if (wrCtrl0 & (state == S_IDLE)) begin
        opReg       <= fspg_op_e'(newOpBits);
        byteMode    <= wDataQ[`FSPG_CTRL_BYTE];
        tempUnprot  <= wDataQ[`FSPG_CTRL_TEMP];    // [RL7] [RL8]
        protConfirm <= newConfirm;
      end else if (cycleEnd & opUnprot) begin
        protConfirm <= 1'b0;                       // [RL3]
      end
      if (wrFire & hitAddr & (state == S_IDLE)) begin
        addrReg <= wDataQ[20:0];
      end
      if (wrFire & hitWdata & (state == S_IDLE)) begin
        wdataReg <= wDataQ[15:0];
      end
    end
  end

  // Hardware sets win over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      doneFlag    <= 1'b0;
      refusedFlag <= 1'b0;
      reprotPend  <= 1'b0;
    end else begin
      doneFlag    <= cycleEnd | (doneFlag & ~(wrStat & wDataQ[`FSPG_ST_DONE]));
      refusedFlag <= refuse | (refusedFlag & ~(wrStat & wDataQ[`FSPG_ST_REFUSED]));
      reprotPend  <= (cycleEnd & opUnprot) |
                     (reprotPend & ~(wrStat & wDataQ[`FSPG_ST_REPROT])); // [RL4]
    end
  end

  // ------------------------------------------------------------
  // Cycle sequencer
  // ------------------------------------------------------------
  fspg_state_e next_state;
  logic [7:0]  next_cnt;
  always_comb begin
    next_state = state;
    next_cnt   = cntZero ? 8'h00 : cnt - 8'h01;
    case (state)
      S_IDLE: begin
        if (start && newOpBits == OP_RESET) begin
          next_state = S_RSTLOW;
          next_cnt   = 8'(`FSPG_RSTLOW_CYC - 1);     // [RL16]
        end else if (start) begin
          next_state = S_SETUP;
          next_cnt   = 8'(`FSPG_SETUP_CYC - 1);
        end
      end
      S_SETUP: begin
        if (cntZero) begin
          next_state = S_STROBE;
          next_cnt   = 8'(`FSPG_STROBE_CYC - 1);     // [RL12]
        end
      end
      S_STROBE, S_RSTLOW: begin
        if (cntZero) begin
          next_state = S_RECOV;
          next_cnt   = 8'(`FSPG_RECOV_CYC - 1);
        end
      end
      S_RECOV: begin
        if (cntZero) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
        next_cnt   = 8'h00;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Pin values
  // ------------------------------------------------------------
  wire        inCycle  = (state == S_SETUP) | (state == S_STROBE);
  wire        strobing = (next_state == S_STROBE);
  wire        driving  = (next_state == S_SETUP) | strobing |
                         ((state == S_STROBE) & (next_state == S_RECOV));
  // Protect selections force A6, A1, A0 on top of the sector address
  wire        selA6    = opUnprot;                                  // [RL1] [RL5] [RL6]
  wire [19:0] next_addr = opProt ? {addrReg[19:7], selA6, addrReg[5:2], 2'b10} : addrReg[19:0];
  // Byte mode floats DQ8..DQ14 and carries A-1 on DQ15
  wire        lsbOnDq15 = byteMode & driving;                       // [RL15] [RL17]
  wire        dataDrive = driving & opIsWrite;
  wire [15:0] next_dqOut = byteMode ? {addrReg[`FSPG_ADDR_LSB_BIT], 7'h00, wdataReg[7:0]}
                                    : wdataReg;
  wire [15:0] next_dqDriveN = byteMode ? {~lsbOnDq15, 7'h7f, {8{~dataDrive}}}
                                       : {16{~dataDrive}};
  // Write strobes only when OE stays high; strobes rest high through reset
  wire        next_weN   = ~(strobing & opIsWrite);                 // [RL13] [RL14]
  wire        next_oeN   = ~(strobing & ~opIsWrite);                // [RL13]
  wire        next_ceN   = ~strobing;
  wire        next_resetN = (next_state != S_RSTLOW);               // [RL16]
  wire        next_hvReset = (tempUnprot | (driving & opInSys)) & next_resetN; // [RL7] [RL18]
  wire        next_hvA9 = driving & opHv;                           // [RL1] [RL6] [RL18]

  always_ff @(posedge clk) begin
    if (srst) begin
      state              <= S_IDLE;
      cnt                <= 8'h00;
      flashAddr          <= 20'h00000;
      dqOut              <= 16'h0000;
      dqDriveN           <= 16'hffff;
      chipEnableN        <= 1'b1;
      outputEnableN      <= 1'b1;
      writeEnableN       <= 1'b1;                                   // [RL14]
      resetN             <= 1'b0;                                   // [RL9]
      byteN              <= 1'b1;
      hvResetQual        <= 1'b0;
      hvAddressNineQual  <= 1'b0;
      hvOutputEnableQual <= 1'b0;
      rdData             <= 16'h0000;
    end else begin
      state              <= next_state;
      cnt                <= next_cnt;
      flashAddr          <= next_addr;
      dqOut              <= next_dqOut;
      dqDriveN           <= next_dqDriveN;
      chipEnableN        <= next_ceN;
      outputEnableN      <= next_oeN;
      writeEnableN       <= next_weN;
      resetN             <= next_resetN;
      byteN              <= ~byteMode;                              // [RL17]
      hvResetQual        <= next_hvReset;
      hvAddressNineQual  <= next_hvA9;
      hvOutputEnableQual <= next_hvA9;
      if ((state == S_STROBE) & cntZero & ~opIsWrite & inCycle) begin
        rdData <= byteMode ? {8'h00, dqSync[7:0]} : dqSync;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin input synchronisers
  // ------------------------------------------------------------
  fspg_sync #(.W(16)) uDqSync (
    .clk     (clk),
    .srst    (srst),
    .pinIn   (dqIn),
    .syncOut (dqSync)
  );
  fspg_sync #(.W(1)) uRdySync (
    .clk     (clk),
    .srst    (srst),
    .pinIn   (rdyBusyN),
    .syncOut (rdySync)
  );
endmodule // fspg_host

// [testbench/fspg_host_chk.sv]
// Pin property checker for the flash protect host controller
`timescale 1ns/1ps
module fspg_host_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Flash pins
  input wire logic [19:0] flashAddr,
  input wire logic [15:0] dqDriveN,
  input wire logic        chipEnableN,
  input wire logic        outputEnableN,
  input wire logic        writeEnableN,
  input wire logic        resetN,
  input wire logic        byteN,
  // Qualifiers
  input wire logic        hvResetQual,
  input wire logic        hvAddressNineQual,
  input wire logic        hvOutputEnableQual
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // Strobe and qualifier relations
  // ----------------------------------------
  property p_wr_decode;
    !writeEnableN |-> !chipEnableN && (outputEnableN || hvOutputEnableQual);
  endproperty
  a_wr_decode: assert property (p_wr_decode) else $error("write strobe badly framed");
  property p_strobe_len;
    $fell(writeEnableN) |-> ##19 !writeEnableN ##1 writeEnableN;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("write strobe width");
  property p_hv_addr;
    hvAddressNineQual |-> flashAddr[1:0] == 2'b10 && hvOutputEnableQual;
  endproperty
  a_hv_addr: assert property (p_hv_addr) else $error("high voltage select address");
  property p_hv_lead;
    $rose(hvAddressNineQual) |-> writeEnableN[*8] ##1 !writeEnableN;
  endproperty
  a_hv_lead: assert property (p_hv_lead) else $error("high voltage setup");
  property p_hv_reset;
    hvResetQual |-> resetN;
  endproperty
  a_hv_reset: assert property (p_hv_reset) else $error("reset qualifier while low");
  property p_rst_len;
    $fell(resetN) |-> ##99 !resetN ##1 resetN;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
  property p_rst_quiet;
    !resetN |-> writeEnableN && chipEnableN && dqDriveN == 16'hffff;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("bus active in reset");
  property p_byte_lanes;
    !byteN |-> dqDriveN[14:8] == 7'h7f;
  endproperty
  a_byte_lanes: assert property (p_byte_lanes) else $error("upper lanes driven");
  property p_byte_lsb;
    !byteN && !writeEnableN |-> !dqDriveN[15];
  endproperty
  a_byte_lsb: assert property (p_byte_lsb) else $error("lowest address bit not driven");
  c_hv: cover property ($rose(hvAddressNineQual));
  c_sys: cover property ($fell(writeEnableN) && hvResetQual);
  c_rst: cover property ($fell(resetN));
endmodule // fspg_host_chk

bind fspg_host fspg_host_chk fspg_host_chk_i (
  .clk, .srst, .flashAddr, .dqDriveN, .chipEnableN, .outputEnableN, .writeEnableN,
  .resetN, .byteN, .hvResetQual, .hvAddressNineQual, .hvOutputEnableQual
);

// [testbench/fspg_flash_model.sv]
// Behavioural model of the parallel flash seen by the host controller
`timescale 1ns/1ps
module fspg_flash_model (
  // Flash pins
  input  wire logic [19:0] flashAddr,
  input  wire logic [15:0] dqOut,
  input  wire logic [15:0] dqDriveN,
  output logic      [15:0] dqIn,
  input  wire logic        chipEnableN,
  input  wire logic        outputEnableN,
  input  wire logic        writeEnableN,
  input  wire logic        resetN,
  input  wire logic        byteN,
  output logic             rdyBusyN,
  // Qualifiers
  input  wire logic        hvResetQual,
  input  wire logic        hvAddressNineQual,
  input  wire logic        hvOutputEnableQual
);
  logic [15:0] mem [128];
  logic [7:0]  prot;
  logic        armed;
  logic        lowSupply;
  logic        flt = 1'b0;
  wire         hvPins = hvAddressNineQual && hvOutputEnableQual;
  wire         oeHigh = outputEnableN || hvOutputEnableQual;
  wire         wrAct  = !chipEnableN && !writeEnableN && oeHigh && resetN;
  wire         rdOn   = !chipEnableN && !outputEnableN && writeEnableN && resetN;
  wire [6:0]   widx   = {flashAddr[19:17], flashAddr[3:0]};
  wire [15:0]  word   = mem[widx];
  wire [15:0]  rv     = byteN ? word : {8'h00, dqOut[15] ? word[15:8] : word[7:0]};
  assign rdyBusyN = resetN;
  // ----------------------------------------
  // Power-up state; protection bits persist
  // ----------------------------------------
  initial begin
    prot = 8'h00;
    lowSupply = 1'b0;
    for (int i = 0; i < 128; i++) mem[i] = 16'h0000;
    armed = (wrAct !== 1'b1);
  end
  // Released lines toggle so a stale value never passes for data
  always #2.5 flt = ~flt;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      dqIn[i] = !dqDriveN[i] ? dqOut[i] : (rdOn && (byteN || i < 8)) ? rv[i] : flt ^ i[0];
    end
  end
  always @(negedge wrAct) armed = 1'b1;
  // Decided 5 ns into the pulse, so shorter noise never commits
  always @(posedge wrAct) begin
    #5;
    if (wrAct && armed && !lowSupply) begin
      if (flashAddr[1:0] == 2'b10 && (hvResetQual || hvPins)) begin
        if (flashAddr[6]) prot = 8'h00;
        else prot[flashAddr[19:17]] = 1'b1;
      end else if (!prot[flashAddr[19:17]] || hvResetQual) begin
        if (byteN) mem[widx] = dqOut;
        else if (dqOut[15]) mem[widx][15:8] = dqOut[7:0];
        else mem[widx][7:0] = dqOut[7:0];
      end
    end
  end
endmodule // fspg_flash_model

// [testbench/tb_fspg_host.sv]
// Self-checking bench for the flash protect host controller
`timescale 1ns/1ps
`include "fspg_cfg.svh"
module tb_fspg_host import fspg_pkg::*; ;
  localparam int LIMIT = 40000;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd, st, rnd;
  logic [19:0] flashAddr;
  logic [15:0] dqOut, dqDriveN, dqIn;
  logic        chipEnableN, outputEnableN, writeEnableN, resetN, byteN, rdyBusyN;
  logic        hvResetQual, hvAddressNineQual, hvOutputEnableQual;
  int          errors = 0;
  int          nChecks = 0;
  int          cycles = 0;
  always #2.5 clk = ~clk;
  fspg_host fspg_host_i (
    .clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .flashAddr, .dqOut, .dqDriveN, .dqIn, .chipEnableN, .outputEnableN, .writeEnableN,
    .resetN, .byteN, .rdyBusyN, .hvResetQual, .hvAddressNineQual, .hvOutputEnableQual
  );
  fspg_flash_model fspg_flash_model_i (
    .flashAddr, .dqOut, .dqDriveN, .dqIn, .chipEnableN, .outputEnableN, .writeEnableN,
    .resetN, .byteN, .rdyBusyN, .hvResetQual, .hvAddressNineQual, .hvOutputEnableQual
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Byte mode leaves the upper lanes floating, so only the low byte is compared
  function automatic logic [31:0] expv(input logic [15:0] d, input logic bm);
    return {16'h0, bm ? {8'h00, d[7:0]} : d};
  endfunction
  task automatic end_of_test;
    if (errors == 0 && nChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1 && s_axi_awvalid) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && s_axi_wvalid) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Flags f are {confirm, temporary unprotect, byte mode}
  task automatic run(input fspg_op_e o, input logic [20:0] a, input logic [15:0] d,
                     input logic [2:0] f);
    axi_wr(`FSPG_OFF_ADDR, {11'h0, a});
    axi_wr(`FSPG_OFF_WDATA, {16'h0, d});
    axi_wr(`FSPG_OFF_CTRL, {23'h0, 1'b1, 1'b0, f, 1'b0, o});
    do axi_rd(`FSPG_OFF_STATUS); while (!(rd[1] || rd[2]));
    st = rd;
    axi_wr(`FSPG_OFF_STATUS, 32'h0000000e);
  endtask
  task automatic wr_chk(input logic [20:0] a, input logic [15:0] d, input logic [15:0] e,
                        input logic [2:0] f);
    run(OP_WRITE, a, d, f);
    run(OP_READ, a, 16'h0, {2'b00, f[0]});
    check(expv(st[31:16], f[0]), expv(e, f[0]));
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    rnd = 32'h7e49;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    axi_rd(`FSPG_OFF_STATUS);
    check(rd & 32'h0000000f, 32'h0);
    axi_rd(8'h10);
    check({30'h0, resp}, 32'h2);
    axi_wr(8'h14, 32'h0);
    check({30'h0, resp}, 32'h2);
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      wr_chk({rnd[5], 16'h0, rnd[3:2], 2'b01}, rnd[31:16], rnd[31:16], {2'b00, rnd[4]});
    end
    run(OP_PROT_HV, 21'h020002, 16'h0, 3'b000);
    wr_chk(21'h020001, 16'h1234, 16'h0000, 3'b000);
    run(OP_PROT_SYS, 21'h040002, 16'h0, 3'b000);
    wr_chk(21'h040001, 16'h5678, 16'h0000, 3'b000);
    run(OP_UNPROT_HV, 21'h000042, 16'h0, 3'b000);
    check({31'h0, st[`FSPG_ST_REFUSED]}, 32'h1);
    run(OP_UNPROT_SYS, 21'h000042, 16'h0, 3'b100);
    check({31'h0, st[`FSPG_ST_REPROT]}, 32'h1);
    wr_chk(21'h020001, 16'h1234, 16'h1234, 3'b000);
    wr_chk(21'h040001, 16'h5678, 16'h5678, 3'b000);
    run(OP_PROT_HV, 21'h020002, 16'h0, 3'b000);
    run(OP_UNPROT_HV, 21'h000042, 16'h0, 3'b100);
    wr_chk(21'h020001, 16'h9abc, 16'h9abc, 3'b000);
    run(OP_PROT_HV, 21'h020002, 16'h0, 3'b000);
    wr_chk(21'h020001, 16'h4321, 16'h4321, 3'b010);
    wr_chk(21'h020001, 16'h1111, 16'h4321, 3'b000);
    run(OP_NONE, 21'h0, 16'h0, 3'b000);
    check({31'h0, st[`FSPG_ST_REFUSED]}, 32'h1);
    run(OP_RESET, 21'h0, 16'h0, 3'b000);
    check({31'h0, st[`FSPG_ST_RDYBUSY]}, 32'h1);
    wr_chk(21'h000005, 16'h2468, 16'h2468, 3'b000);
    end_of_test();
  end
endmodule // tb_fspg_host
